// File: logic/external_bus_pin_select.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "pin_select_params.svh"

module external_bus_pin_select (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [`ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire pin_select_pkg::word_t s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [`ADDR_W-1:0]    s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output pin_select_pkg::word_t      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    input  wire logic [23:0]           bus_addr,
    input  wire logic [15:0]           bus_wdata,
    input  wire logic                  bus_data_drive,
    input  wire logic                  bus_latch,
    input  wire logic                  bus_read,
    input  wire logic                  bus_store_low,
    output logic [15:0]                bus_rdata,
    input  wire logic [`PIN_COUNT-1:0] pins_in,
    output logic [`PIN_COUNT-1:0]      pins_out,
    output logic [`PIN_COUNT-1:0]      pins_oe,
    output logic [`PIN_COUNT-1:0]      pins_pullup
);
    import pin_select_pkg::*;

    // Reset release
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    // Pin input synchroniser
    logic [`PIN_COUNT-1:0] pins_stable;

    pin_input_sync u_sync (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .pins_raw    (pins_in),
        .pins_stable (pins_stable)
    );

    // Register state
    logic [1:0]            ctrl;
    logic [7:0]            upper_address_pin_select;
    logic [`PIN_COUNT-1:0] port_out;
    logic [`PIN_COUNT-1:0] port_dir;
    logic [`PIN_COUNT-1:0] port_pullup;
    logic [15:0]           capture;
    logic [1:0]            next_ctrl;
    logic [7:0]            next_upper_address_pin_select;
    logic [`PIN_COUNT-1:0] next_port_out;
    logic [`PIN_COUNT-1:0] next_port_dir;
    logic [`PIN_COUNT-1:0] next_port_pullup;
    logic [15:0]           next_capture;
    logic                  ext;
    logic                  wren;

    assign ext  = ctrl[`CTRL_EXT_BUS];
    assign wren = ctrl[`CTRL_WR_EN];

    // Pin ownership
    logic [`PIN_COUNT-1:0] bus_own;
    logic [`PIN_COUNT-1:0] bus_val;
    logic [`PIN_COUNT-1:0] bus_oe;
    logic [15:0]           ad_val;
    logic                  ad_oe;

    always_comb begin
        ad_val = bus_latch ? bus_addr[15:0] : bus_wdata;
        ad_oe  = bus_latch | bus_data_drive;
        bus_own = {5'h00,
                   ext & wren,
                   ext,
                   ext,
                   ext ? ~upper_address_pin_select : 8'h00,
                   {8{ext}},
                   {8{ext}}};
        bus_val = {5'h00, ~bus_store_low, ~bus_read, bus_latch, bus_addr[23:16], ad_val};
        bus_oe  = {5'h00, 3'b111, 8'hff, {16{ad_oe}}};
    end

    // Pin outputs
    logic [`PIN_COUNT-1:0] next_pins_out;
    logic [`PIN_COUNT-1:0] next_pins_oe;
    logic [`PIN_COUNT-1:0] next_pins_pullup;

    always_comb begin
        next_pins_out    = (bus_own & bus_val) | (~bus_own & port_out);
        next_pins_oe     = (bus_own & bus_oe) | (~bus_own & port_dir);
        next_pins_pullup = ~bus_own & port_pullup & ~port_dir;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins_out    <= `RST_PORT;
            pins_oe     <= `RST_PORT;
            pins_pullup <= `RST_PORT;
        end else begin
            pins_out    <= next_pins_out;
            pins_oe     <= next_pins_oe;
            pins_pullup <= next_pins_pullup;
        end
    end

    // Register read decode
    function automatic word_t reg_read(input logic [`ADDR_W-1:0] a);
        word_t v;
        v = `RESERVED_FILL;
        if (a == `OFF_CTRL) begin
            v = {30'h0, ctrl};
        end else if (a == `OFF_UPPER_SEL) begin
            v = {24'h0, upper_address_pin_select};
        end else if (a == `OFF_PORT_OUT) begin
            v = port_out;
        end else if (a == `OFF_PORT_DIR) begin
            v = port_dir;
        end else if (a == `OFF_PORT_PULLUP) begin
            v = port_pullup;
        end else if (a == `OFF_PORT_IN) begin
            v = pins_stable;
        end else if (a == `OFF_STATUS) begin
            v = {21'h0, bus_own[26:16]};
        end else if (a == `OFF_BUS_CAPTURE) begin
            v = {16'h0, capture};
        end
        return v;
    endfunction: reg_read

    function automatic word_t merge_bytes(input word_t old, input word_t val,
                                          input logic [3:0] strb);
        word_t res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res;
    endfunction: merge_bytes

    // Write channel
    wr_state_t          wr_state;
    wr_state_t          next_wr_state;
    logic               aw_held;
    logic               w_held;
    logic [`ADDR_W-1:0] aw_addr;
    word_t              w_data;
    logic [3:0]         w_strb;
    logic               next_aw_held;
    logic               next_w_held;
    logic [`ADDR_W-1:0] next_aw_addr;
    word_t              next_w_data;
    logic [3:0]         next_w_strb;
    logic               wr_do;

    always_comb begin
        next_wr_state = wr_state;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        wr_do         = 1'b0;
        s_axi_awready = rst_n && (wr_state == WR_IDLE) && !aw_held;
        s_axi_wready  = rst_n && (wr_state == WR_IDLE) && !w_held;
        case (wr_state)
            WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    next_aw_held = 1'b1;
                    next_aw_addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    next_w_held = 1'b1;
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                end
                if (next_aw_held && next_w_held) begin
                    wr_do         = 1'b1;
                    next_wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = WR_IDLE;
                    next_aw_held  = 1'b0;
                    next_w_held   = 1'b0;
                end
            end
            default: begin
                next_wr_state = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_state <= WR_IDLE;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= `OFF_CTRL;
            w_data   <= `RST_PORT;
            w_strb   <= 4'h0;
        end else begin
            wr_state <= next_wr_state;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
        end
    end

    assign s_axi_bvalid = (wr_state == WR_RESP);
    assign s_axi_bresp  = `RESP_OKAY;

    // Register update
    word_t wr_word;

    always_comb begin
        wr_word = merge_bytes(reg_read(next_aw_addr), next_w_data, next_w_strb);
        next_ctrl                     = ctrl;
        next_upper_address_pin_select = upper_address_pin_select;
        next_port_out                 = port_out;
        next_port_dir                 = port_dir;
        next_port_pullup              = port_pullup;
        next_capture                  = capture;
        if (ext && bus_read) begin
            next_capture = pins_stable[15:0];
        end
        if (wr_do) begin
            if (next_aw_addr == `OFF_CTRL) begin
                next_ctrl = wr_word[1:0];
            end else if (next_aw_addr == `OFF_UPPER_SEL) begin
                next_upper_address_pin_select = wr_word[7:0];
            end else if (next_aw_addr == `OFF_PORT_OUT) begin
                next_port_out = wr_word;
            end else if (next_aw_addr == `OFF_PORT_DIR) begin
                next_port_dir = wr_word;
            end else if (next_aw_addr == `OFF_PORT_PULLUP) begin
                next_port_pullup = wr_word;
            end else begin
                next_ctrl = ctrl;             // Other addresses leave state alone
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl                     <= `RST_CTRL;
            upper_address_pin_select <= `RST_UPPER_SEL;
            port_out                 <= `RST_PORT;
            port_dir                 <= `RST_PORT;
            port_pullup              <= `RST_PORT;
            capture                  <= `RST_CAPTURE;
        end else begin
            ctrl                     <= next_ctrl;
            upper_address_pin_select <= next_upper_address_pin_select;
            port_out                 <= next_port_out;
            port_dir                 <= next_port_dir;
            port_pullup              <= next_port_pullup;
            capture                  <= next_capture;
        end
    end

    assign bus_rdata = capture;

    // Read channel
    rd_state_t rd_state;
    rd_state_t next_rd_state;
    word_t     rdata;
    word_t     next_rdata;

    always_comb begin
        next_rd_state = rd_state;
        next_rdata    = rdata;
        s_axi_arready = rst_n && (rd_state == RD_IDLE);
        case (rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    next_rdata    = reg_read(s_axi_araddr);
                    next_rd_state = RD_RESP;
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = RD_IDLE;
                end
            end
            default: begin
                next_rd_state = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_state <= RD_IDLE;
            rdata    <= `RST_PORT;
        end else begin
            rd_state <= next_rd_state;
            rdata    <= next_rdata;
        end
    end

    assign s_axi_rvalid = (rd_state == RD_RESP);
    assign s_axi_rdata  = rdata;
    assign s_axi_rresp  = `RESP_OKAY;

    // Checks
    logic ar_mapped;

    assign ar_mapped = s_axi_araddr inside {`OFF_CTRL, `OFF_UPPER_SEL, `OFF_PORT_OUT,
                                            `OFF_PORT_DIR, `OFF_PORT_PULLUP, `OFF_PORT_IN,
                                            `OFF_STATUS, `OFF_BUS_CAPTURE};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_LOW_BUS: assert property (
        ext && bus_latch |=> pins_oe[7:0] == 8'hff && pins_out[7:0] == $past(bus_addr[7:0]))
        else $error("Low pins do not carry the latched address");
    AST_LOW_PORT: assert property (
        !ext |=> pins_pullup[7:0] == $past(port_pullup[7:0] & ~port_dir[7:0]))
        else $error("Low pins lost their port pull-up in single-chip mode");
    AST_HIGH_BUS: assert property (
        ext && !bus_latch && bus_data_drive
        |=> pins_oe[15:8] == 8'hff && pins_out[15:8] == $past(bus_wdata[15:8]))
        else $error("High pins do not carry write data");
    AST_PORT2_PORT: assert property (
        ext |=> ((pins_oe[23:16] ^ $past(port_dir[23:16]))
                 & $past(upper_address_pin_select)) == 8'h00)
        else $error("Selected port-2 pin not following its direction");
    AST_PORT2_ADDR: assert property (
        ext |=> ((pins_out[23:16] ^ $past(bus_addr[23:16]))
                 & ~$past(upper_address_pin_select)) == 8'h00
                && (pins_oe[23:16] | $past(upper_address_pin_select)) == 8'hff)
        else $error("Port-2 pin not driving its upper address bit");
    AST_LATCH_PIN: assert property (
        ext |=> pins_oe[24] && pins_out[24] == $past(bus_latch))
        else $error("Latch strobe pin wrong");
    AST_READ_PIN: assert property (
        ext |=> pins_oe[25] && pins_out[25] == !$past(bus_read))
        else $error("Read strobe pin wrong");
    AST_STORE_PORT: assert property (
        !(ext && wren) |=> pins_oe[26] == $past(port_dir[26])
                           && pins_out[26] == $past(port_out[26]))
        else $error("Port-3 pin 2 not a port pin");
    AST_STORE_DRIVE: assert property (
        ext && wren && bus_store_low ##1 ext && wren && !bus_store_low
        |-> pins_oe[26] && !pins_out[26] ##1 pins_out[26])
        else $error("Low byte store strobe not driven");
    AST_PULL_ONLY_INPUT: assert property (
        (pins_pullup & pins_oe) == 32'h00000000)
        else $error("Pull-up active on a driven pin");
    AST_RESERVED_READ: assert property (
        s_axi_arvalid && s_axi_arready && !ar_mapped
        |=> s_axi_rvalid && s_axi_rdata == `RESERVED_FILL)
        else $error("Reserved read returned the wrong value");
    AST_RELEASE: assert property (
        !ext |=> pins_out == $past(port_out) && pins_oe == $past(port_dir))
        else $error("Pins not returned to port settings");

    COV_STORE: cover property (ext && wren && bus_store_low ##1 !bus_store_low);
    COV_RESERVED: cover property (s_axi_arvalid && s_axi_arready && !ar_mapped);
    COV_BUS_OFF: cover property ($fell(ext));
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);

endmodule: external_bus_pin_select

`default_nettype wire

// File: logic/pin_select_params.svh
`ifndef PIN_SELECT_PARAMS_SVH
`define PIN_SELECT_PARAMS_SVH

// Pin count and register address width
`define PIN_COUNT        32
`define ADDR_W           8

// Register byte offsets
`define OFF_CTRL         8'h00
`define OFF_UPPER_SEL    8'h04
`define OFF_PORT_OUT     8'h08
`define OFF_PORT_DIR     8'h0c
`define OFF_PORT_PULLUP  8'h10
`define OFF_PORT_IN      8'h14
`define OFF_STATUS       8'h18
`define OFF_BUS_CAPTURE  8'h1c

// Control field positions
`define CTRL_EXT_BUS     0
`define CTRL_WR_EN       1

// Reset values
`define RST_CTRL         2'h0
`define RST_UPPER_SEL    8'hff
`define RST_PORT         32'h00000000
`define RST_CAPTURE      16'h0000

// Value returned for reserved addresses
`define RESERVED_FILL    32'h00000000

// Response code
`define RESP_OKAY        2'b00

`endif

// File: logic/pin_select_pkg.sv
`default_nettype none

package pin_select_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_t;

endpackage: pin_select_pkg

`default_nettype wire

// File: logic/pin_input_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "pin_select_params.svh"

module pin_input_sync (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [`PIN_COUNT-1:0] pins_raw,
    output logic      [`PIN_COUNT-1:0] pins_stable
);

    // Three stages per pin; a level is taken once stages two and three agree
    for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_bit
        logic [2:0] stage;
        logic       stable;
        logic       next_stable;

        always_comb begin
            next_stable = stable;
            if (stage[1] == stage[2]) begin
                next_stable = stage[2];
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                stage  <= 3'b000;
                stable <= 1'b0;
            end else begin
                stage  <= {stage[1:0], pins_raw[i]};
                stable <= next_stable;
            end
        end

        assign pins_stable[i] = stable;
    end

endmodule: pin_input_sync

`default_nettype wire

// File: verification/ext_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none

module ext_bus_partner #(
    parameter int RD_DELAY = 4
) (
    input  wire logic        clk_sys,
    input  wire logic [31:0] pins_out,
    input  wire logic [31:0] pins_oe,
    input  wire logic [31:0] pins_pullup,
    input  wire logic [31:0] ext_drive,
    input  wire logic [31:0] ext_val,
    output logic      [31:0] pins_in
);
    logic [15:0] mem [int];
    logic [23:0] addr = 24'h0;
    logic [15:0] rd_data = 16'h0;
    logic [31:0] last_in = 32'h0;
    logic [31:0] rd_mask;
    logic        rd_on;
    int          wait_cnt = 0;

    // Answer a read only once the strobe has stood low long enough
    assign rd_on = pins_oe[25] && !pins_out[25] && wait_cnt >= RD_DELAY
                   && pins_oe[15:0] == 16'h0;
    assign rd_mask = rd_on ? 32'h0000ffff : 32'h0;
    // Released lines carrying no read data and not driven from outside show the pull-up or the inverse of their last level
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & rd_mask & {16'h0, rd_data})
                   | (~pins_oe & ~rd_mask & ext_drive & ext_val)
                   | (~pins_oe & ~rd_mask & ~ext_drive & (pins_pullup | ~last_in));

    always @(posedge clk_sys) begin
        last_in <= pins_in;
        if (pins_oe[24] && pins_out[24]) addr <= pins_out[23:0];
        if (pins_oe[26] && !pins_out[26]) mem[addr] = pins_out[15:0];
        wait_cnt <= (pins_oe[25] && !pins_out[25]) ? wait_cnt + 1 : 0;
        rd_data <= mem.exists(addr) ? mem[addr] : ~addr[15:0];
    end
endmodule: ext_bus_partner

`default_nettype wire

// File: verification/external_bus_pin_select_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pin_select_params.svh"

module external_bus_pin_select_tb_top;
    import pin_select_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, m_usel;
    logic [1:0]  bresp, rresp, m_ctrl;
    word_t       wdata = 32'h0, rdata, got, eo, ee, ep, es, ein, m_out, m_dir, m_pu;
    word_t       pins_in, pins_out, pins_oe, pins_pullup, mask;
    word_t       ext_val = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic [23:0] bus_addr = 24'h0;
    logic [15:0] bus_wdata = 16'h0, bus_rdata, hold;
    logic        bus_data_drive = 1'b0, bus_latch = 1'b0, bus_read = 1'b0, bus_store_low = 1'b0;
    logic [15:0] exp_mem [int];
    logic [23:0] adr_q [$];
    int          fail_count = 0, checks_done = 0, seed;

    always #5 clk_sys = ~clk_sys;

    external_bus_pin_select dut (
        .clk_sys(clk_sys), .rstn(rstn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_data_drive(bus_data_drive),
        .bus_latch(bus_latch), .bus_read(bus_read), .bus_store_low(bus_store_low),
        .bus_rdata(bus_rdata), .pins_in(pins_in), .pins_out(pins_out),
        .pins_oe(pins_oe), .pins_pullup(pins_pullup)
    );

    ext_bus_partner #(.RD_DELAY(4)) far_side (
        .clk_sys(clk_sys), .pins_out(pins_out), .pins_oe(pins_oe),
        .pins_pullup(pins_pullup), .ext_drive(32'hffffffff), .ext_val(ext_val),
        .pins_in(pins_in)
    );

    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask: summarize

    task automatic check(input word_t g, input word_t e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask: check

    task automatic axi_write(input logic [7:0] a, input word_t d);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                check({30'h0, bresp}, 32'(`RESP_OKAY));
            end
        end
        if (!done) fail_count++;
        // One idle edge so the next transfer never re-raises bready in this step
        @(posedge clk_sys);
    endtask: axi_write

    task automatic axi_read(input logic [7:0] a, output word_t d);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                rready <= 1'b0;
                check({30'h0, rresp}, 32'(`RESP_OKAY));
            end
        end
        if (!done) fail_count++;
        @(posedge clk_sys);
    endtask: axi_read

    task automatic rd_check(input logic [7:0] a, input word_t e);
        axi_read(a, got);
        check(got, e);
    endtask: rd_check

    task automatic set_regs();
        axi_write(`OFF_CTRL, {30'h0, m_ctrl});
        axi_write(`OFF_UPPER_SEL, {24'h0, m_usel});
        axi_write(`OFF_PORT_OUT, m_out);
        axi_write(`OFF_PORT_DIR, m_dir);
        axi_write(`OFF_PORT_PULLUP, m_pu);
    endtask: set_regs

    task automatic bus_cycle(input logic wr, input logic [23:0] a, input logic [15:0] d);
        bus_addr <= a;
        bus_latch <= 1'b1;
        @(posedge clk_sys);
        bus_latch <= 1'b0;
        bus_wdata <= d;
        bus_data_drive <= wr;
        bus_store_low <= wr;
        bus_read <= ~wr;
        repeat (12) @(posedge clk_sys);
        bus_store_low <= 1'b0;
        bus_read <= 1'b0;
        @(posedge clk_sys);
        bus_data_drive <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask: bus_cycle

    task automatic model();
        word_t own, bv;
        own = m_ctrl[0] ? {5'h0, m_ctrl[1], 2'b11, ~m_usel, 16'hffff} : 32'h0;
        bv = {5'h0, ~bus_store_low, ~bus_read, bus_latch, bus_addr[23:16],
              bus_latch ? bus_addr[15:0] : bus_wdata};
        ee = (m_dir & ~own) | (own & {16'hffff, {16{bus_latch | bus_data_drive}}});
        eo = (m_out & ~own) | (own & bv);
        ep = m_pu & ~m_dir & ~own;
        es = {21'h0, own[26:16]};
        ein = (eo & ee) | (ext_val & ~ee);
    endtask: model

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end

    initial begin
        seed = $urandom(32'he8cf1c8c);
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(pins_oe, 32'h0);
        rd_check(`OFF_CTRL, 32'(`RST_CTRL));
        rd_check(`OFF_UPPER_SEL, 32'(`RST_UPPER_SEL));
        rd_check(`OFF_PORT_DIR, `RST_PORT);
        rd_check(8'h20, `RESERVED_FILL);
        for (int k = 0; k < 24; k++) begin
            m_ctrl = k[1:0];
            m_usel = 8'($urandom);
            m_out = $urandom;
            m_dir = $urandom;
            m_pu = $urandom;
            set_regs();
            bus_addr <= 24'($urandom);
            bus_wdata <= 16'($urandom);
            {bus_latch, bus_read, bus_store_low, bus_data_drive} <= 4'($urandom);
            ext_val <= $urandom;
            repeat (8) @(posedge clk_sys);
            model();
            mask = (m_ctrl[0] && bus_read) ? 32'hffff0000 : 32'hffffffff;
            check(pins_oe, ee);
            check(pins_out & ee, eo & ee);
            check(pins_pullup, ep);
            rd_check(`OFF_STATUS, es);
            rd_check(`OFF_CTRL, {30'h0, m_ctrl});
            rd_check(`OFF_UPPER_SEL, {24'h0, m_usel});
            axi_read(`OFF_PORT_IN, got);
            check(got & mask, ein & mask);
        end
        wstrb <= 4'h5;
        axi_write(`OFF_PORT_OUT, ~m_out);
        wstrb <= 4'hf;
        rd_check(`OFF_PORT_OUT, m_out ^ 32'h00ff00ff);
        bus_latch <= 1'b0;
        bus_read <= 1'b0;
        bus_store_low <= 1'b0;
        bus_data_drive <= 1'b0;
        m_ctrl = 2'h3;
        m_usel = 8'h00;
        m_dir = 32'h0;
        m_pu = 32'h0;
        set_regs();
        for (int k = 0; k < 4; k++) begin
            adr_q.push_back(24'($urandom));
            exp_mem[adr_q[k]] = 16'($urandom);
            bus_cycle(1'b1, adr_q[k], exp_mem[adr_q[k]]);
        end
        foreach (adr_q[k]) begin
            bus_cycle(1'b0, adr_q[k], 16'h0);
            check({16'h0, bus_rdata}, {16'h0, exp_mem[adr_q[k]]});
        end
        m_ctrl = 2'h1;
        set_regs();
        bus_cycle(1'b1, adr_q[0], ~exp_mem[adr_q[0]]);
        bus_cycle(1'b0, adr_q[0], 16'h0);
        hold = bus_rdata;
        check({16'h0, hold}, {16'h0, exp_mem[adr_q[0]]});
        m_ctrl = 2'h0;
        set_regs();
        bus_cycle(1'b0, adr_q[1], 16'h0);
        check({16'h0, bus_rdata}, {16'h0, hold});
        summarize();
    end
endmodule: external_bus_pin_select_tb_top

`default_nettype wire
